// ---- inc/light_defines.svh ----
`ifndef LIGHT_DEFINES_SVH
`define LIGHT_DEFINES_SVH

// configuration word after reset: auto range, long time, shutdown, latch
`define CFG_RESET     16'hC810
`define MODE_SHUT     2'h0
`define MODE_SINGLE   2'h1
`define RANGE_AUTO    4'hC
`define RANGE_MAX     4'hB
`define RANGE_LOW     4'h0
`define RANGE_DROP1   4'h5
`define DROP_NONE     2'h0
`define DROP_ONE      2'h1
`define DROP_TWO      2'h2
`define DROP_THREE    2'h3
`define CT_SHORT      1'b0
`define CT_SHORT_MS   100
`define CT_LONG_MS    800
`define CLK_HZ        100000000
`define MS_PER_S      1000
`define MANT_ALL      12'hFFF
`define CNT_ONE       4'h1
`define CNT_ZERO      4'h0

`endif

// ---- inc/light_pkg.sv ----
package light_pkg;

  // configuration register layout, bit 15 first
  typedef struct packed {
    logic [3:0] range_select;
    logic       conversion_time_sel;
    logic [1:0] mode;
    logic       overrange_ind;
    logic       conversion_done_ind;
    logic       over_threshold_ind;
    logic       under_threshold_ind;
    logic       latch;
    logic       polarity;
    logic       mask_exp;
    logic [1:0] fault_count_sel;
  } cfg_t;

  // result and limit word: exponent over mantissa
  typedef struct packed {
    logic [3:0]  exponent;
    logic [11:0] mantissa;
  } light_word_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } conv_state_t;

endpackage

// ---- logic/conv_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
module conv_timer
  import light_pkg::*;
#(
  parameter int W = 30
)
(
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // control
  input  wire logic         start,
  input  wire logic         stop,
  input  wire logic [W-1:0] length,
  // status
  output logic              running,
  output logic              done
);

  logic [W-1:0] cnt_r;
  logic         run_r;
  wire  [W-1:0] last_cnt = length - W'(1);

  assign done    = run_r && (cnt_r == last_cnt);
  assign running = run_r;

  // start wins so a back-to-back restart needs no idle cycle
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end
    else if (start)
    begin
      cnt_r <= '0;
      run_r <= 1'b1;
    end
    else if (stop || done)
    begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end
    else if (run_r)
      cnt_r <= cnt_r + W'(1);
  end

endmodule
`default_nettype wire

// ---- logic/light_conv_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "light_defines.svh"
module light_conv_ctrl
  import light_pkg::*;
#(
  parameter int unsigned SHORT_CYC =
    `CT_SHORT_MS * (`CLK_HZ / `MS_PER_S),
  parameter int unsigned LONG_CYC =
    `CT_LONG_MS * (`CLK_HZ / `MS_PER_S),
  parameter int TW = 30
)
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // configuration register access
  input  wire logic        cfg_wr,
  input  wire logic [15:0] cfg_wdata,
  input  wire logic        cfg_rd,
  output logic      [15:0] cfg_rdata,
  // threshold limits
  input  wire logic [15:0] high_limit,
  input  wire logic [15:0] low_limit,
  // integrating front end
  input  wire logic        fe_overload,
  input  wire logic [11:0] fe_mant,
  // results and status
  output logic      [15:0] result_word,
  output logic      [3:0]  range_active,
  output logic             converting,
  output logic             alert
);

  cfg_t        cfg_r, cfg_nxt, wcfg;
  conv_state_t state_r, state_nxt;
  light_word_t res_r, res_nxt;
  logic [3:0]  act_range_r, act_range_nxt;
  logic        ovl_r, ovl_nxt;
  logic [3:0]  hi_cnt_r, lo_cnt_r, hi_cnt_nxt, lo_cnt_nxt;
  logic        t_done, t_run;

  function automatic logic [26:0] to_linear(input light_word_t w);
    to_linear = 27'(w.mantissa) << w.exponent;
  endfunction

  // short time loses low bits in the sensitive ranges
  function automatic logic [1:0] drop_bits(input logic [3:0] rng,
                                           input logic       ct);
    if (ct != `CT_SHORT || rng > `RANGE_DROP1)
      drop_bits = `DROP_NONE;
    else if (rng == `RANGE_DROP1)
      drop_bits = `DROP_ONE;
    else if (rng == `RANGE_LOW)
      drop_bits = `DROP_THREE;
    else
      drop_bits = `DROP_TWO;
  endfunction

  // range a new conversion begins in; reserved codes use the top one
  function automatic logic [3:0] first_range(input logic [3:0] rng);
    if (rng == `RANGE_AUTO)
      first_range = `RANGE_LOW;
    else if (rng > `RANGE_MAX)
      first_range = `RANGE_MAX;
    else
      first_range = rng;
  endfunction

  // decode
  assign wcfg = cfg_t'(cfg_wdata);
  wire wr_runs   = (wcfg.mode != `MODE_SHUT);
  wire cur_runs  = (cfg_r.mode != `MODE_SHUT);
  wire is_single = (cfg_r.mode == `MODE_SINGLE);
  wire auto_rng  = (cfg_r.range_select == `RANGE_AUTO);
  wire [3:0] new_rng = first_range(cfg_wr ? wcfg.range_select
                                          : cfg_r.range_select);
  wire in_conv   = (state_r == ST_CONV);
  wire step_up   = in_conv && !cfg_wr && auto_rng && fe_overload
                && (act_range_r < `RANGE_MAX);
  // an overload on the last cycle still steps up, so auto range
  // never flags overrange below the top range
  wire done_evt  = in_conv && t_done && !cfg_wr && !step_up;
  wire start_new = (cfg_wr && wr_runs)
                || (done_evt && cur_runs && !is_single);
  wire t_start   = start_new || step_up;
  wire t_stop    = cfg_wr || done_evt;
  wire [TW-1:0] t_len = cfg_r.conversion_time_sel
                      ? TW'(LONG_CYC) : TW'(SHORT_CYC);
  wire [1:0]  drop = drop_bits(act_range_r, cfg_r.conversion_time_sel);
  wire [11:0] keep = `MANT_ALL << drop;
  wire [11:0] mant_q = fe_mant & keep;
  wire light_word_t meas = '{exponent: act_range_r, mantissa: mant_q};
  wire [26:0] meas_lin = to_linear(meas);
  wire above = meas_lin > to_linear(light_word_t'(high_limit));
  wire below = meas_lin < to_linear(light_word_t'(low_limit));
  wire [3:0] need = `CNT_ONE << cfg_r.fault_count_sel;
  // manual: any overload; auto: only overload at the top range
  wire ovf_now = ovl_r || fe_overload;

  conv_timer #(
    .W (TW)
  ) u_timer (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .start   (t_start),
    .stop    (t_stop),
    .length  (t_len),
    .running (t_run),
    .done    (t_done)
  );

  always_comb
  begin
    cfg_nxt       = cfg_r;
    state_nxt     = state_r;
    res_nxt       = res_r;
    act_range_nxt = act_range_r;
    ovl_nxt       = ovl_r;
    hi_cnt_nxt    = hi_cnt_r;
    lo_cnt_nxt    = lo_cnt_r;
    if (cfg_wr)
    begin
      // status bits keep their state; conversion_done_ind clears on a read or a run write
      cfg_nxt.range_select        = wcfg.range_select;
      cfg_nxt.conversion_time_sel = wcfg.conversion_time_sel;
      cfg_nxt.mode                = wcfg.mode;
      cfg_nxt.latch               = wcfg.latch;
      cfg_nxt.polarity            = wcfg.polarity;
      cfg_nxt.mask_exp            = wcfg.mask_exp;
      cfg_nxt.fault_count_sel     = wcfg.fault_count_sel;
      state_nxt = wr_runs ? ST_CONV : ST_IDLE;
    end
    if (cfg_rd || (cfg_wr && wr_runs))
      cfg_nxt.conversion_done_ind = 1'b0;
    if (done_evt)
    begin
      cfg_nxt.conversion_done_ind = 1'b1;
      cfg_nxt.overrange_ind       = ovf_now;
      res_nxt = meas;
      hi_cnt_nxt = !above ? `CNT_ZERO
                 : (hi_cnt_r < need) ? hi_cnt_r + `CNT_ONE : hi_cnt_r;
      lo_cnt_nxt = !below ? `CNT_ZERO
                 : (lo_cnt_r < need) ? lo_cnt_r + `CNT_ONE : lo_cnt_r;
      cfg_nxt.over_threshold_ind  = (hi_cnt_nxt >= need);
      cfg_nxt.under_threshold_ind = (lo_cnt_nxt >= need);
      if (is_single)
      begin
        cfg_nxt.mode = `MODE_SHUT;
        state_nxt    = ST_IDLE;
      end
    end
    if (start_new)
    begin
      act_range_nxt = new_rng;
      ovl_nxt = 1'b0;
    end
    else if (step_up)
    begin
      act_range_nxt = act_range_r + `CNT_ONE;
      ovl_nxt       = 1'b0;
    end
    else if (in_conv && fe_overload)
      ovl_nxt = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_r       <= cfg_t'(`CFG_RESET);
      state_r     <= ST_IDLE;
      res_r       <= '0;
      act_range_r <= `RANGE_LOW;
      ovl_r       <= 1'b0;
      hi_cnt_r    <= `CNT_ZERO;
      lo_cnt_r    <= `CNT_ZERO;
    end
    else
    begin
      cfg_r       <= cfg_nxt;
      state_r     <= state_nxt;
      res_r       <= res_nxt;
      act_range_r <= act_range_nxt;
      ovl_r       <= ovl_nxt;
      hi_cnt_r    <= hi_cnt_nxt;
      lo_cnt_r    <= lo_cnt_nxt;
    end
  end

  assign cfg_rdata    = cfg_r;
  assign result_word  = res_r;
  assign range_active = act_range_r;
  assign converting   = in_conv;
  // alert follows the retained flags only
  assign alert = cfg_r.over_threshold_ind || cfg_r.under_threshold_ind;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // cycles since the timer last started, counted apart from the timer
  logic [TW-1:0] age_r;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      age_r <= '0;
    else if (t_start)
      age_r <= TW'(1);
    else if (t_run)
      age_r <= age_r + TW'(1);
  end

  a_ready_on_done: assert property (
    done_evt |=> cfg_r.conversion_done_ind)
    else $error("ready flag not set after completion");

  a_ready_read_clr: assert property (
    cfg_rd && !done_evt |=> !cfg_r.conversion_done_ind)
    else $error("ready flag survived a read");

  a_write_clr_ready: assert property (
    cfg_wr && wr_runs |=> !cfg_r.conversion_done_ind)
    else $error("ready flag survived a run write");

  a_shut_keeps_flags: assert property (
    cfg_wr && !wr_runs && !cfg_rd
    |=> $stable(cfg_r.conversion_done_ind) && $stable(alert)
        && !converting)
    else $error("shutdown write disturbed flags");

  a_alert_holds: assert property (
    !done_evt |=> $stable(alert))
    else $error("alert moved without a completion");

  a_single_readback: assert property (
    in_conv && is_single && !cfg_wr && !done_evt
    |=> is_single && converting)
    else $error("single shot mode did not read back");

  a_single_ends_shut: assert property (
    done_evt && is_single |=> cfg_r.mode == `MODE_SHUT && !converting)
    else $error("single shot did not return to shutdown");

  a_write_aborts: assert property (
    in_conv && cfg_wr && !cfg_rd
    |=> converting == $past(wr_runs)
        && cfg_r.conversion_done_ind
           == ($past(cfg_r.conversion_done_ind) && !$past(wr_runs)))
    else $error("aborted conversion reported ready");

  a_auto_step: assert property (
    step_up |=> act_range_r == $past(act_range_r) + `CNT_ONE
                && converting)
    else $error("auto range did not step up");

  a_auto_no_ovf: assert property (
    done_evt && auto_rng && (act_range_r < `RANGE_MAX)
    |=> !cfg_r.overrange_ind)
    else $error("overrange set below the top auto range");

  a_continuous_run: assert property (
    done_evt && cfg_r.mode[1] |=> converting [*2])
    else $error("continuous mode stopped");

  a_status_ro: assert property (
    cfg_wr && !done_evt && !cfg_rd
    |=> $stable(cfg_r.overrange_ind) && $stable(cfg_r.over_threshold_ind)
        && $stable(cfg_r.under_threshold_ind))
    else $error("write changed read-only status");

  a_time_select: assert property (
    done_evt |-> age_r == (cfg_r.conversion_time_sel
                           ? TW'(LONG_CYC) : TW'(SHORT_CYC)))
    else $error("conversion length does not match time bit");

  c_single_shot: cover property (done_evt && is_single);
  c_auto_step:   cover property (step_up);
  c_over_flag:   cover property (done_evt && above ##1 alert);
  c_read_clear:  cover property (cfg_rd && cfg_r.conversion_done_ind);

endmodule
`default_nettype wire

// ---- tb/fe_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module fe_model
  import light_pkg::*;
(
  // conversion state
  input  wire logic        converting,
  input  wire logic [3:0]  range_active,
  // light level as exponent over mantissa
  input  wire logic [15:0] light,
  // front end outputs
  output logic             fe_overload,
  output logic [11:0]      fe_mant
);
  wire logic [3:0] le = light[15:12];
  wire logic       hot = le > range_active;
  assign fe_overload = converting && hot;
  // idle front end shows junk, not the last sample
  assign fe_mant = !converting ? ~light[11:0] : hot ? 12'hFFF
                 : light[11:0] >> (range_active - le);
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import light_pkg::*;
  ;
  localparam int SC = 20;
  localparam int LC = 160;
  logic        ref_clk, rst_n, cfg_wr, cfg_rd, converting, alert;
  logic        fe_overload;
  logic [15:0] cfg_wdata, cfg_rdata, high_limit, low_limit, light;
  logic [15:0] result_word, c;
  logic [11:0] fe_mant;
  logic [3:0]  range_active;
  int          n_mismatch, compares, cyc, need;

  light_conv_ctrl #(.SHORT_CYC(SC), .LONG_CYC(LC)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
    .high_limit(high_limit), .low_limit(low_limit),
    .fe_overload(fe_overload), .fe_mant(fe_mant),
    .result_word(result_word), .range_active(range_active),
    .converting(converting), .alert(alert));

  fe_model fe_u (.converting(converting), .range_active(range_active),
    .light(light), .fe_overload(fe_overload), .fe_mant(fe_mant));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one-cycle write (w=1) or read (w=0) strobe
  task automatic acc(input logic w, input logic [15:0] d);
    @(posedge ref_clk);
    cfg_wr    <= w;
    cfg_rd    <= !w;
    cfg_wdata <= d;
    @(posedge ref_clk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
    #1 c = cfg_rdata;
  endtask

  // write, then wait out the conversion with a bound
  task automatic run(input logic [15:0] d);
    acc(1'b1, d);
    cyc = 0;
    while (converting === 1'b1 && cyc < 3000)
    begin
      @(posedge ref_clk);
      #1 cyc++;
    end
    c = cfg_rdata;
    chk(16'(cyc < 3000), 16'h0001);
  endtask

  task automatic stop_test;
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial
  begin
    #200000;
    n_mismatch++;
    stop_test;
  end

  initial
  begin
    {rst_n, cfg_wr, cfg_rd} = 3'h0;
    cfg_wdata  = 16'h0000;
    high_limit = 16'h3800;
    low_limit  = 16'h3200;
    light      = 16'h3456;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1 chk(cfg_rdata, 16'hC810);
    acc(1'b1, 16'h3A00);
    chk(c, 16'h3A00);
    run(16'h3A00);
    chk(16'(cyc >= LC - 2 && cyc <= LC + 2), 16'h0001);
    chk(c, 16'h3880);
    chk(result_word, 16'h3456);
    acc(1'b1, 16'h3800);
    chk(c, 16'h3880);
    acc(1'b0, 16'h0000);
    chk(c, 16'h3800);
    acc(1'b1, 16'h39E0);
    chk(c, 16'h3800);
    $display("test single shot done");
    light <= 16'h5456;
    run(16'h3200);
    chk(16'(cyc >= SC - 2 && cyc <= SC + 2), 16'h0001);
    chk(c, 16'h31C0);
    chk(result_word, 16'h3FFC);
    chk(16'(alert), 16'h0001);
    light <= 16'h3456;
    run(16'h3200);
    chk(c, 16'h3080);
    light <= 16'h3100;
    run(16'h3200);
    chk(16'(c[5]), 16'h0001);
    acc(1'b1, 16'h3000);
    chk(16'({c[7], c[5], alert}), 16'h0007);
    $display("test flags done");
    for (int r = 0; r < 7; r++)
    begin
      light <= {r[3:0], 12'h457};
      run({r[3:0], 12'h200});
      chk(result_word, {r[3:0], 12'h457 & ~((12'h1 <<
        (r == 0 ? 3 : r < 5 ? 2 : r == 5 ? 1 : 0)) - 12'h1)});
    end
    $display("test resolution done");
    for (int f = 0; f < 4; f++)
    begin
      need = 1 << f;
      light <= 16'h3456;
      run(16'h3200 | 16'(f));
      light <= 16'h3900;
      for (int k = 1; k <= need; k++)
      begin
        run(16'h3200 | 16'(f));
        chk(16'(c[6]), 16'(k == need));
      end
    end
    $display("test fault count done");
    light <= 16'h5456;
    run(16'hC200);
    chk({range_active, 11'h0, c[8]}, 16'h5000);
    chk(result_word, 16'h5456);
    light <= 16'hF456;
    run(16'hC200);
    chk({range_active, 11'h0, c[8]}, 16'hB001);
    light <= 16'h3456;
    run(16'hE200);
    chk({range_active, result_word[11:0]}, 16'hB004);
    $display("test auto range done");
    light <= 16'h3456;
    acc(1'b1, 16'h3A00);
    repeat (10) @(posedge ref_clk);
    run(16'h3200);
    chk(16'(cyc >= SC - 2 && cyc <= SC + 2), 16'h0001);
    repeat (LC) @(posedge ref_clk);
    #1 chk(16'(converting), 16'h0000);
    for (int m = 2; m < 4; m++)
    begin
      acc(1'b1, {4'h3, 1'b0, m[1:0], 9'h000});
      repeat (3 * SC + 5) @(posedge ref_clk);
      #1 chk({cfg_rdata[10:7], 11'h0, converting},
        {m[1:0], 2'h1, 12'h001});
    end
    acc(1'b1, 16'h3000);
    $display("test continuous and abort done");
    stop_test;
  end
endmodule
`default_nettype wire
